// *** verilog/amps_host.sv ***
// Host sequencer: power-up, shutdown and power-down of the amplifier
// Behaviour
// - Hold reset 100 us, then wait 13.5 ms
// - Trim oscillator, then wait 50 ms
// - Processor config, other registers, then exit shutdown
// - Normal operation: volume, mute, shutdown only
// - Shutdown moves wait 240 ms plus ramp
// - Enter shutdown, wait 1 ms plus stop ramp
// - Reconfigure allowed while in shutdown
// - Exit shutdown, wait 1 ms plus start ramp
// - Device may delay exit 240 ms after trim
// - Power-down: shutdown or power_down_n low, then reset
// - Inputs low after reset low 2 us
// - Two compressors, high band and low band
// - Compressor coefficients at fixed subaddresses
// - Threshold 9.23, other coefficients 3.23
// - Mixer gains 26 bits, 3.23
// - Coefficients are two's complement
// - Gains sent as four-byte words
// - 9.17 gains, unity is 131072
// - Upper subaddresses take whole 4-byte words
// - Coefficient in bits 25..0 of word
//
// Our own choice: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module amps_host #(
	parameter int unsigned RST_WAIT_CYC  = amps_pkg::RST_WAIT_CYC,
	parameter int unsigned TRIM_WAIT_CYC = amps_pkg::TRIM_WAIT_CYC,
	parameter int unsigned GUARD_CYC     = amps_pkg::GUARD_CYC,
	parameter int unsigned RAMP_BASE_CYC = amps_pkg::RAMP_BASE_CYC,
	parameter int unsigned LOSS_CYC      = amps_pkg::LOSS_CYC,
	parameter int unsigned RAMP_STEP_CYC = amps_pkg::RAMP_STEP_CYC
) (
	input  wire logic        clk_in,
	input  wire logic        nrst_in,
	input  wire logic        ce_in,
	input  wire logic [3:0]  addr_in,
	input  wire logic [31:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [31:0] rdata_out,
	amps_link_if.host        link
);
	amps_pkg::amps_state_e state;
	logic [31:0] now;
	logic [31:0] mark;
	logic [31:0] need;
	logic [31:0] t_trim;
	logic        trimmed;
	logic        guard_done;
	logic        pd_pend;
	logic        rst_n_q;
	logic        pdn_q;
	logic        frame_q;
	logic        vld_q;
	logic [7:0]  dat_q;
	logic [39:0] tx_sr;
	logic [2:0]  tx_left;
	logic        tx_keep;
	logic        fsm_go;
	logic [7:0]  fsm_sub;
	logic [7:0]  fsm_dat;
	logic [8:0]  sub_reg;
	logic [7:0]  ramp_sh;
	logic        err;
	logic        waited;
	logic        link_idle;
	logic        ctl_wr;
	logic        data_wr;
	logic        sub_ok;
	logic        sw_go;
	logic        wide;
	logic [39:0] sw_sr;
	logic [31:0] start_cyc;
	logic [31:0] stop_cyc;
	logic [31:0] guard_need;
	logic        up_ok;
	logic        exit_ok;
	logic        enter_ok;
	logic        pd_ok;
	logic        loss_ok;
	logic        cmd_ok;
	logic [4:0]  cmd;

	assign link.reset_n = rst_n_q;
	assign link.power_down_n = pdn_q;
	assign link.frame = frame_q;
	assign link.byte_vld = vld_q;
	assign link.byte_dat = dat_q;

	// Waits measured against a free-running counter
	assign waited = (now - mark) >= need;
	assign start_cyc = 32'(ramp_sh[3:0]) * 32'(RAMP_STEP_CYC);
	assign stop_cyc = 32'(ramp_sh[7:4]) * 32'(RAMP_STEP_CYC);
	assign guard_need = 32'(GUARD_CYC) + amps_pkg::amps_scale13(start_cyc);
	assign link_idle = tx_left == 3'd0 && !frame_q && !fsm_go;
	assign ctl_wr = wr_in && addr_in == amps_pkg::HR_CTRL;
	assign data_wr = wr_in && addr_in == amps_pkg::HR_DATA;
	assign cmd = wdata_in[4:0];

	// Software access window: config in shutdown, narrow set in run
	always_comb begin
		sub_ok = 1'b0;
		if (state == amps_pkg::AMPS_STBY) begin
			sub_ok = 1'b1;
		end else if (state == amps_pkg::AMPS_RUN) begin
			sub_ok = sub_reg[7:0] == amps_pkg::SUB_MUTE ||
				(sub_reg[7:0] >= amps_pkg::SUB_VOL_LO &&
				sub_reg[7:0] <= amps_pkg::SUB_VOL_HI);
		end
	end
	assign sw_go = data_wr && sub_ok && tx_left == 3'd0 && !fsm_go;
	assign wide = sub_reg[7:0] >= amps_pkg::SUB_MULTI;
	// Upper subaddresses always carry a whole 4-byte word
	assign sw_sr = wide ? {sub_reg[7:0], wdata_in} :
		{sub_reg[7:0], wdata_in[7:0], 24'h0};

	assign up_ok = state == amps_pkg::AMPS_OFF;
	// Shutdown moves blocked until the post-trim guard expires
	assign exit_ok = state == amps_pkg::AMPS_STBY && guard_done && link_idle;
	assign enter_ok = state == amps_pkg::AMPS_RUN && guard_done && link_idle;
	assign pd_ok = state == amps_pkg::AMPS_STBY ||
		(state == amps_pkg::AMPS_RUN && link_idle);
	assign loss_ok = state != amps_pkg::AMPS_OFF &&
		state != amps_pkg::AMPS_LOSS_WAIT &&
		state != amps_pkg::AMPS_PD_RESET;
	assign cmd_ok = (cmd[amps_pkg::CTL_UP] && up_ok) ||
		(cmd[amps_pkg::CTL_EXIT] && exit_ok) ||
		(cmd[amps_pkg::CTL_ENTER] && enter_ok) ||
		(cmd[amps_pkg::CTL_PD] && pd_ok) ||
		(cmd[amps_pkg::CTL_LOSS] && loss_ok);

	// Free-running cycle counter
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			now <= 32'h0;
		end else if (ce_in) begin
			now <= now + 32'h1;
		end
	end

	// Post-trim guard, sticky so counter wrap cannot undo it
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			guard_done <= 1'b0;
		end else if (ce_in) begin
			if (!trimmed) begin
				guard_done <= 1'b0;
			end else if ((now - t_trim) >= guard_need) begin
				guard_done <= 1'b1;
			end
		end
	end

	// Sequencing state machine
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			state <= amps_pkg::AMPS_OFF;
			mark <= 32'h0;
			need <= 32'h0;
			t_trim <= 32'h0;
			trimmed <= 1'b0;
			pd_pend <= 1'b0;
			rst_n_q <= 1'b0;
			pdn_q <= 1'b0;
			fsm_go <= 1'b0;
			fsm_sub <= 8'h0;
			fsm_dat <= 8'h0;
		end else if (ce_in) begin
			fsm_go <= 1'b0;
			if (ctl_wr && cmd[amps_pkg::CTL_LOSS] && loss_ok) begin
				pdn_q <= 1'b0; // Sudden loss
				mark <= now;
				need <= 32'(LOSS_CYC);
				state <= amps_pkg::AMPS_LOSS_WAIT;
			end else begin
				unique case (state)
				amps_pkg::AMPS_OFF: if (ctl_wr && cmd[amps_pkg::CTL_UP]) begin
					rst_n_q <= 1'b0;
					pdn_q <= 1'b1;
					mark <= now;
					need <= 32'(amps_pkg::RST_HOLD_CYC);
					state <= amps_pkg::AMPS_RST_HOLD;
				end
				amps_pkg::AMPS_RST_HOLD: if (waited) begin
					rst_n_q <= 1'b1;
					mark <= now;
					need <= 32'(RST_WAIT_CYC);
					state <= amps_pkg::AMPS_RST_WAIT;
				end
				amps_pkg::AMPS_RST_WAIT: if (waited) begin
					fsm_go <= 1'b1; // Oscillator trim
					fsm_sub <= amps_pkg::SUB_TRIM;
					fsm_dat <= amps_pkg::TRIM_VAL;
					state <= amps_pkg::AMPS_TRIM_SEND;
				end
				amps_pkg::AMPS_TRIM_SEND: if (link_idle) begin
					mark <= now;
					t_trim <= now;
					trimmed <= 1'b1;
					need <= 32'(TRIM_WAIT_CYC);
					state <= amps_pkg::AMPS_TRIM_WAIT;
				end
				amps_pkg::AMPS_TRIM_WAIT: if (waited) begin
					state <= amps_pkg::AMPS_STBY;
				end
				amps_pkg::AMPS_STBY: if (ctl_wr) begin
					if (cmd[amps_pkg::CTL_PD]) begin
						rst_n_q <= 1'b0; // Already shut down
						mark <= now;
						need <= 32'(amps_pkg::RST_LOW_CYC);
						state <= amps_pkg::AMPS_PD_RESET;
					end else if (cmd[amps_pkg::CTL_EXIT] && exit_ok) begin
						fsm_go <= 1'b1;
						fsm_sub <= amps_pkg::SUB_SHUTDOWN;
						fsm_dat <= amps_pkg::SD_EXIT_VAL;
						state <= amps_pkg::AMPS_EXIT_SEND;
					end
				end
				amps_pkg::AMPS_EXIT_SEND: if (link_idle) begin
					mark <= now;
					need <= 32'(RAMP_BASE_CYC) +
						amps_pkg::amps_scale13(start_cyc);
					state <= amps_pkg::AMPS_EXIT_WAIT;
				end
				amps_pkg::AMPS_EXIT_WAIT: if (waited) begin
					state <= amps_pkg::AMPS_RUN;
				end
				amps_pkg::AMPS_RUN: if (ctl_wr && (enter_ok &&
					(cmd[amps_pkg::CTL_ENTER] || cmd[amps_pkg::CTL_PD]) ||
					cmd[amps_pkg::CTL_PD] && pd_ok)) begin
					fsm_go <= 1'b1; // Shut down first
					fsm_sub <= amps_pkg::SUB_SHUTDOWN;
					fsm_dat <= amps_pkg::SD_ENTER_VAL;
					pd_pend <= cmd[amps_pkg::CTL_PD];
					state <= amps_pkg::AMPS_ENTER_SEND;
				end
				amps_pkg::AMPS_ENTER_SEND: if (link_idle) begin
					mark <= now;
					need <= 32'(RAMP_BASE_CYC) +
						amps_pkg::amps_scale13(stop_cyc);
					state <= amps_pkg::AMPS_ENTER_WAIT;
				end
				amps_pkg::AMPS_ENTER_WAIT: if (waited) begin
					if (pd_pend) begin
						rst_n_q <= 1'b0;
						mark <= now;
						need <= 32'(amps_pkg::RST_LOW_CYC);
						state <= amps_pkg::AMPS_PD_RESET;
					end else begin
						state <= amps_pkg::AMPS_STBY;
					end
				end
				amps_pkg::AMPS_LOSS_WAIT: if (waited) begin
					rst_n_q <= 1'b0;
					mark <= now;
					need <= 32'(amps_pkg::RST_LOW_CYC);
					state <= amps_pkg::AMPS_PD_RESET;
				end
				amps_pkg::AMPS_PD_RESET: if (waited) begin
					pdn_q <= 1'b0; // All inputs low now
					pd_pend <= 1'b0;
					trimmed <= 1'b0;
					state <= amps_pkg::AMPS_OFF;
				end
				default: state <= amps_pkg::AMPS_OFF;
				endcase
			end
		end
	end

	// Byte transmitter: subaddress first, then data MSB first
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			tx_sr <= 40'h0;
			tx_left <= 3'd0;
			tx_keep <= 1'b0;
			frame_q <= 1'b0;
			vld_q <= 1'b0;
			dat_q <= 8'h0;
		end else if (ce_in) begin
			if (state == amps_pkg::AMPS_OFF) begin
				tx_left <= 3'd0; // Inputs held low
				frame_q <= 1'b0;
				vld_q <= 1'b0;
				dat_q <= 8'h0;
			end else if (tx_left != 3'd0) begin
				frame_q <= 1'b1;
				vld_q <= 1'b1;
				dat_q <= tx_sr[39:32];
				tx_sr <= {tx_sr[31:0], 8'h0};
				tx_left <= tx_left - 3'd1;
			end else begin
				vld_q <= 1'b0;
				frame_q <= frame_q && tx_keep;
				if (fsm_go) begin
					tx_sr <= {fsm_sub, fsm_dat, 24'h0};
					tx_left <= 3'd2;
					tx_keep <= 1'b0;
				end else if (sw_go) begin
					tx_sr <= frame_q ? {sw_sr[31:0], 8'h0} : sw_sr;
					tx_left <= (wide ? 3'd5 : 3'd2) - {2'd0, frame_q};
					tx_keep <= sub_reg[amps_pkg::SUB_KEEP];
				end
			end
		end
	end

	// Register port, ramp shadow and sticky refusal flag
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sub_reg <= 9'h0;
			ramp_sh <= amps_pkg::RST_RAMP;
			err <= 1'b0;
			rdata_out <= 32'h0;
		end else if (ce_in) begin
			if (wr_in && addr_in == amps_pkg::HR_SUB) begin
				sub_reg <= wdata_in[8:0];
			end
			if (state == amps_pkg::AMPS_OFF) begin
				ramp_sh <= amps_pkg::RST_RAMP;
			end else if (sw_go && sub_reg[7:0] == amps_pkg::SUB_RAMP) begin
				ramp_sh <= wdata_in[7:0];
			end
			// Set wins over clear
			err <= (err && !(wr_in && addr_in == amps_pkg::HR_STATUS &&
				wdata_in[amps_pkg::ST_ERR])) ||
				(ctl_wr && cmd != 5'h0 && !cmd_ok) || (data_wr && !sw_go);
			rdata_out <= 32'h0;
			if (rd_in) begin
				unique case (addr_in)
				amps_pkg::HR_STATUS: rdata_out <= {16'h0, ramp_sh, trimmed,
					err, guard_done, !link_idle, state};
				amps_pkg::HR_SUB: rdata_out <= {23'h0, sub_reg};
				default: rdata_out <= 32'h0;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

// *** inc/amps_pkg.sv ***
// Shared constants and types of the amplifier sequencer link
package amps_pkg;
	localparam int unsigned CLK_KHZ      = 20000;
	localparam int unsigned RST_HOLD_US  = 100;
	localparam int unsigned RST_HOLD_CYC = (RST_HOLD_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned RST_WAIT_US  = 13500;
	localparam int unsigned RST_WAIT_CYC = (RST_WAIT_US * CLK_KHZ + 999) / 1000;
	localparam int unsigned TRIM_WAIT_MS = 50;
	localparam int unsigned TRIM_WAIT_CYC = TRIM_WAIT_MS * CLK_KHZ;
	localparam int unsigned GUARD_MS     = 240;
	localparam int unsigned GUARD_CYC    = GUARD_MS * CLK_KHZ;
	localparam int unsigned RAMP_BASE_MS = 1;
	localparam int unsigned RAMP_BASE_CYC = RAMP_BASE_MS * CLK_KHZ;
	localparam int unsigned LOSS_MS      = 2;
	localparam int unsigned LOSS_CYC     = LOSS_MS * CLK_KHZ;
	localparam int unsigned RST_LOW_US   = 2;
	localparam int unsigned RST_LOW_CYC  = RST_LOW_US * CLK_KHZ / 1000;
	localparam int unsigned RAMP_STEP_US = 1000;
	localparam int unsigned RAMP_STEP_CYC = RAMP_STEP_US * CLK_KHZ / 1000;
	// Device subaddresses
	localparam logic [7:0] SUB_SHUTDOWN = 8'h05;
	localparam logic [7:0] SUB_MUTE     = 8'h06;
	localparam logic [7:0] SUB_VOL_LO   = 8'h07;
	localparam logic [7:0] SUB_VOL_HI   = 8'h0a;
	localparam logic [7:0] SUB_RAMP     = 8'h1a;
	localparam logic [7:0] SUB_TRIM     = 8'h1b;
	localparam logic [7:0] SUB_MULTI    = 8'h20;
	localparam logic [7:0] SUB_C1_THR   = 8'h3b;
	localparam logic [7:0] SUB_C1_AVG   = 8'h3c;
	localparam logic [7:0] SUB_C1_AD    = 8'h40;
	localparam logic [7:0] SUB_C2_THR   = 8'h3e;
	localparam logic [7:0] SUB_C2_AVG   = 8'h3f;
	localparam logic [7:0] SUB_C2_AD    = 8'h43;
	localparam logic [7:0] SD_ENTER_VAL = 8'h40;
	localparam logic [7:0] SD_EXIT_VAL  = 8'h00;
	localparam logic [7:0] TRIM_VAL     = 8'h00;
	localparam int unsigned SD_BIT      = 6;
	localparam logic [7:0] RST_SHUTDOWN = 8'h40;
	localparam logic [7:0] RST_RAMP     = 8'h0f;
	localparam logic [7:0] RST_MUTE     = 8'h00;
	localparam logic [31:0] UNITY_9_17  = 32'h0002_0000;
	localparam int unsigned COEF_W      = 26;
	// Host register port
	localparam logic [3:0] HR_STATUS = 4'h0;
	localparam logic [3:0] HR_CTRL   = 4'h1;
	localparam logic [3:0] HR_SUB    = 4'h2;
	localparam logic [3:0] HR_DATA   = 4'h3;
	localparam int unsigned CTL_UP   = 0;
	localparam int unsigned CTL_EXIT = 1;
	localparam int unsigned CTL_ENTER = 2;
	localparam int unsigned CTL_PD   = 3;
	localparam int unsigned CTL_LOSS = 4;
	localparam int unsigned SUB_KEEP = 8;
	localparam int unsigned ST_ERR   = 6;
	typedef enum logic [3:0] {
		AMPS_OFF = 4'h0, AMPS_RST_HOLD = 4'h1, AMPS_RST_WAIT = 4'h2,
		AMPS_TRIM_SEND = 4'h3, AMPS_TRIM_WAIT = 4'h4, AMPS_STBY = 4'h5,
		AMPS_EXIT_SEND = 4'h6, AMPS_EXIT_WAIT = 4'h7, AMPS_RUN = 4'h8,
		AMPS_ENTER_SEND = 4'h9, AMPS_ENTER_WAIT = 4'ha,
		AMPS_LOSS_WAIT = 4'hb, AMPS_PD_RESET = 4'hc
	} amps_state_e;
	// Rounds 1.3 times x upward
	function automatic logic [31:0] amps_scale13(input logic [31:0] x);
		return x + (x * 32'd3 + 32'd9) / 32'd10;
	endfunction
endpackage

// *** inc/amps_link_if.sv ***
// Link between the sequencing host and the amplifier device
`timescale 1ns/100ps
`default_nettype none
interface amps_link_if;
	logic       reset_n;
	logic       power_down_n;
	logic       frame;
	logic       byte_vld;
	logic [7:0] byte_dat;
	modport host(output reset_n, power_down_n, frame, byte_vld, byte_dat);
	modport device(input reset_n, power_down_n, frame, byte_vld, byte_dat);
endinterface
`default_nettype wire

// *** verilog/amps_comp_store.sv ***
// One compressor coefficient store with full-set commit
`timescale 1ns/100ps
`default_nettype none
module amps_comp_store #(
	parameter logic [7:0] SUB_THR = 8'h00,
	parameter logic [7:0] SUB_AVG = 8'h00,
	parameter logic [7:0] SUB_AD  = 8'h00
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic         ce_in,
	input  wire logic         clr_in,
	input  wire logic         word_vld_in,
	input  wire logic [7:0]   sub_in,
	input  wire logic [1:0]   idx_in,
	input  wire logic [31:0]  word_in,
	output logic      [31:0]  thr_out,
	output logic      [191:0] coef_out
);
	logic [25:0] stage [0:2];
	logic [31:0] sx;

	// Sign-extend 3.23 coefficient from bits 25..0
	assign sx = {{6{word_in[25]}}, word_in[25:0]};

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			thr_out <= 32'h0;
			coef_out <= 192'h0;
			stage[0] <= 26'h0;
			stage[1] <= 26'h0;
			stage[2] <= 26'h0;
		end else if (ce_in) begin
			if (clr_in) begin
				thr_out <= 32'h0;
				coef_out <= 192'h0;
			end else if (word_vld_in) begin
				if (sub_in == SUB_THR) begin
					thr_out <= word_in; // Full 9.23 word
				end else if (sub_in == SUB_AVG || sub_in == SUB_AD) begin
					stage[idx_in[1:0] == 2'd3 ? 2'd2 : idx_in] <= word_in[25:0];
					// Commit only a complete set
					if (sub_in == SUB_AVG && idx_in == 2'd1) begin
						coef_out[31:0] <= {{6{stage[0][25]}}, stage[0]};
						coef_out[63:32] <= sx;
					end
					if (sub_in == SUB_AD && idx_in == 2'd3) begin
						coef_out[95:64] <= {{6{stage[0][25]}}, stage[0]};
						coef_out[127:96] <= {{6{stage[1][25]}}, stage[1]};
						coef_out[159:128] <= {{6{stage[2][25]}}, stage[2]};
						coef_out[191:160] <= sx;
					end
				end
			end
		end
	end
endmodule
`default_nettype wire

// *** verilog/amps_device.sv ***
// Amplifier device end: register intake, shutdown and compressors
`timescale 1ns/100ps
`default_nettype none
module amps_device #(
	parameter int unsigned GUARD_CYC = amps_pkg::GUARD_CYC
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic         ce_in,
	amps_link_if.device       link,
	output logic              shutdown_out,
	output logic      [31:0]  gain_out,
	output logic      [7:0]   ramp_out,
	output logic              trimmed_out,
	output logic      [31:0]  cmp1_thr_out,
	output logic      [191:0] cmp1_coef_out,
	output logic      [31:0]  cmp2_thr_out,
	output logic      [191:0] cmp2_coef_out
);
	logic        first;
	logic [7:0]  sub;
	logic [1:0]  bcnt;
	logic [1:0]  widx;
	logic [23:0] acc;
	logic        word_vld;
	logic [7:0]  wsub;
	logic [1:0]  wpos;
	logic [31:0] word;
	logic [7:0]  sd_reg;
	logic [7:0]  mute_reg;
	logic [31:0] guard_cnt;
	logic        byte_in;
	logic        byte_wr;
	logic [1:0]  last_idx;

	assign byte_in = link.frame && link.byte_vld;
	assign byte_wr = byte_in && !first && sub < amps_pkg::SUB_MULTI;
	// Index of the last word in one coefficient set
	assign last_idx = (sub == amps_pkg::SUB_C1_AVG ||
		sub == amps_pkg::SUB_C2_AVG) ? 2'd1 :
		(sub == amps_pkg::SUB_C1_AD ||
		sub == amps_pkg::SUB_C2_AD) ? 2'd3 : 2'd0;

	// Byte intake, sequential addressing, 4-byte words
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			first <= 1'b1;
			sub <= 8'h0;
			bcnt <= 2'd0;
			widx <= 2'd0;
			acc <= 24'h0;
			word_vld <= 1'b0;
			wsub <= 8'h0;
			wpos <= 2'd0;
			word <= 32'h0;
		end else if (ce_in) begin
			word_vld <= 1'b0;
			if (!link.frame || !link.reset_n) begin
				first <= 1'b1;
				bcnt <= 2'd0; // Partial word dropped
				widx <= 2'd0;
			end else if (link.byte_vld) begin
				if (first) begin
					sub <= link.byte_dat;
					first <= 1'b0;
				end else if (sub < amps_pkg::SUB_MULTI) begin
					sub <= sub + 8'h1;
				end else begin
					bcnt <= bcnt + 2'd1;
					acc <= {acc[15:0], link.byte_dat};
					if (bcnt == 2'd3) begin
						word_vld <= 1'b1;
						word <= {acc, link.byte_dat};
						wsub <= sub;
						wpos <= widx;
						if (widx == last_idx) begin
							widx <= 2'd0;
							sub <= sub + 8'h1;
						end else begin
							widx <= widx + 2'd1;
						end
					end
				end
			end
		end
	end

	// Single-byte control registers and exit guard after trim
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			sd_reg <= amps_pkg::RST_SHUTDOWN;
			ramp_out <= amps_pkg::RST_RAMP;
			mute_reg <= amps_pkg::RST_MUTE;
			trimmed_out <= 1'b0;
			guard_cnt <= 32'h0;
		end else if (ce_in) begin
			if (!link.reset_n) begin
				sd_reg <= amps_pkg::RST_SHUTDOWN;
				ramp_out <= amps_pkg::RST_RAMP;
				mute_reg <= amps_pkg::RST_MUTE;
				trimmed_out <= 1'b0;
				guard_cnt <= 32'h0;
			end else begin
				if (guard_cnt != 32'h0) begin
					guard_cnt <= guard_cnt - 32'h1;
				end
				if (byte_wr) begin
					if (sub == amps_pkg::SUB_SHUTDOWN) begin
						sd_reg <= link.byte_dat;
					end
					if (sub == amps_pkg::SUB_RAMP) begin
						ramp_out <= link.byte_dat;
					end
					if (sub == amps_pkg::SUB_MUTE) begin
						mute_reg <= link.byte_dat;
					end
					if (sub == amps_pkg::SUB_TRIM) begin
						trimmed_out <= 1'b1;
						guard_cnt <= 32'(GUARD_CYC);
					end
				end
			end
		end
	end

	// Shutdown held while exit guard runs; gain in 9.17
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			shutdown_out <= 1'b1;
			gain_out <= 32'h0;
		end else if (ce_in) begin
			shutdown_out <= !link.power_down_n || !link.reset_n ||
				sd_reg[amps_pkg::SD_BIT] || !trimmed_out ||
				guard_cnt != 32'h0;
			gain_out <= (mute_reg != 8'h0) ? 32'h0 : amps_pkg::UNITY_9_17;
		end
	end

	// Two compressors: high band and low band
	amps_comp_store #(
		.SUB_THR(amps_pkg::SUB_C1_THR),
		.SUB_AVG(amps_pkg::SUB_C1_AVG),
		.SUB_AD (amps_pkg::SUB_C1_AD)
	) u_cmp_high (
		.clk_in     (clk_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.clr_in     (!link.reset_n),
		.word_vld_in(word_vld),
		.sub_in     (wsub),
		.idx_in     (wpos),
		.word_in    (word),
		.thr_out    (cmp1_thr_out),
		.coef_out   (cmp1_coef_out)
	);
	amps_comp_store #(
		.SUB_THR(amps_pkg::SUB_C2_THR),
		.SUB_AVG(amps_pkg::SUB_C2_AVG),
		.SUB_AD (amps_pkg::SUB_C2_AD)
	) u_cmp_low (
		.clk_in     (clk_in),
		.nrst_in    (nrst_in),
		.ce_in      (ce_in),
		.clr_in     (!link.reset_n),
		.word_vld_in(word_vld),
		.sub_in     (wsub),
		.idx_in     (wpos),
		.word_in    (word),
		.thr_out    (cmp2_thr_out),
		.coef_out   (cmp2_coef_out)
	);
endmodule
`default_nettype wire

// *** test/amps_link_monitor.sv ***
// Checker of the link between host and device ends
`timescale 1ns/100ps
`default_nettype none
module amps_link_monitor #(
	parameter int unsigned RST_WAIT_CYC  = 20,
	parameter int unsigned TRIM_WAIT_CYC = 20,
	parameter int unsigned RAMP_BASE_CYC = 10,
	parameter int unsigned LOSS_CYC      = 10
) (
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	input  wire logic       reset_n,
	input  wire logic       power_down_n,
	input  wire logic       frame,
	input  wire logic       byte_vld,
	input  wire logic [7:0] byte_dat
);
	logic [15:0] low_cnt;
	logic [15:0] high_cnt;
	logic [15:0] gap;
	logic [7:0]  sub;
	logic [7:0]  nbytes;
	logic [15:0] pdn_low;
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			low_cnt <= 16'h0000;
			high_cnt <= 16'h0000;
			gap <= 16'h0000;
			sub <= 8'h00;
			nbytes <= 8'h00;
			pdn_low <= 16'h0000;
		end else begin
			pdn_low <= power_down_n ? 16'h0000 : pdn_low + {15'h0000, ~&pdn_low};
			low_cnt <= reset_n ? 16'h0000 : low_cnt + {15'h0000, ~&low_cnt};
			high_cnt <= reset_n ? high_cnt + {15'h0000, ~&high_cnt} : 16'h0000;
			gap <= frame ? 16'h0000 : gap + {15'h0000, ~&gap};
			if ($rose(frame))
				sub <= byte_dat;
			nbytes <= frame ? nbytes + {7'h00, byte_vld} : 8'h00;
		end
	end
	property p_rst_hold;
		$rose(reset_n) |-> low_cnt >= amps_pkg::RST_HOLD_CYC && power_down_n;
	endproperty
	a_rst_hold: assert property (p_rst_hold) else $error("reset hold short");
	property p_rst_wait;
		$rose(frame) && byte_dat == amps_pkg::SUB_TRIM |-> high_cnt >= RST_WAIT_CYC;
	endproperty
	a_rst_wait: assert property (p_rst_wait) else $error("trim too early");
	property p_trim_val;
		$rose(frame) && byte_dat == amps_pkg::SUB_TRIM
			|=> byte_vld && byte_dat == amps_pkg::TRIM_VAL ##1 !frame;
	endproperty
	a_trim_val: assert property (p_trim_val) else $error("trim value");
	property p_trim_wait;
		$rose(frame) && sub == amps_pkg::SUB_TRIM |-> gap >= TRIM_WAIT_CYC - 1;
	endproperty
	a_trim_wait: assert property (p_trim_wait) else $error("trim wait");
	property p_sd_wait;
		$rose(frame) && sub == amps_pkg::SUB_SHUTDOWN |-> gap >= RAMP_BASE_CYC;
	endproperty
	a_sd_wait: assert property (p_sd_wait) else $error("shutdown wait");
	property p_word;
		$fell(frame) && sub >= amps_pkg::SUB_MULTI |-> nbytes[1:0] == 2'b01;
	endproperty
	a_word: assert property (p_word) else $error("partial word");
	property p_vld_frame;
		byte_vld |-> frame;
	endproperty
	a_vld_frame: assert property (p_vld_frame) else $error("byte outside");
	property p_quiet;
		!reset_n |-> !frame && !byte_vld;
	endproperty
	a_quiet: assert property (p_quiet) else $error("traffic in reset");
	property p_pdn_late;
		$fell(power_down_n) && !reset_n |-> low_cnt >= amps_pkg::RST_LOW_CYC;
	endproperty
	a_pdn_late: assert property (p_pdn_late) else $error("inputs low early");
	property p_loss;
		$fell(reset_n) && !power_down_n |-> pdn_low >= LOSS_CYC;
	endproperty
	a_loss: assert property (p_loss) else $error("loss wait short");
	c_trim: cover property ($rose(frame) && byte_dat == amps_pkg::SUB_TRIM);
	c_word: cover property ($fell(frame) && sub >= amps_pkg::SUB_MULTI);
	c_loss: cover property ($fell(power_down_n) && reset_n);
	c_pd: cover property ($fell(power_down_n) && !reset_n);
endmodule
`default_nettype wire

// *** test/amp_init_shutdown_sequencer_test.sv ***
// Bench joining host and device ends
`timescale 1ns/100ps
`default_nettype none
module amp_init_shutdown_sequencer_test;
	localparam int unsigned TW = 20, TG = 50, TB = 10, TS = 4;
	logic        clk_in = 1'b0;
	logic        ce = 1'b1;
	logic [191:0] coef1;
	logic [191:0] coef2;
	logic        nrst_in = 1'b0;
	logic [3:0]  addr_in = 4'h0;
	logic [31:0] wdata_in = 32'h0;
	logic        wr_in = 1'b0;
	logic        rd_in = 1'b0;
	logic [31:0] rdata_out;
	logic        sd;
	logic [31:0] gain;
	logic [7:0]  ramp;
	logic        trimmed;
	logic [31:0] thr1;
	logic [31:0] thr2;
	logic [31:0] st;
	int          num_errors = 0;
	int          comparisons = 0;
	int          cycles = 0;
	amps_link_if link();
	always #25 clk_in = ~clk_in;
	amps_host #(.RST_WAIT_CYC(TW), .TRIM_WAIT_CYC(TW), .GUARD_CYC(TG),
		.RAMP_BASE_CYC(TB), .LOSS_CYC(TB), .RAMP_STEP_CYC(TS)) i_amps_host (
		.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
		.rdata_out(rdata_out), .link(link));
	amps_device #(.GUARD_CYC(TG)) i_amps_device (.clk_in(clk_in),
		.nrst_in(nrst_in), .ce_in(ce), .link(link), .shutdown_out(sd),
		.gain_out(gain), .ramp_out(ramp), .trimmed_out(trimmed),
		.cmp1_thr_out(thr1), .cmp1_coef_out(coef1), .cmp2_thr_out(thr2),
		.cmp2_coef_out(coef2));
	amps_link_monitor #(.RST_WAIT_CYC(TW), .TRIM_WAIT_CYC(TW),
		.RAMP_BASE_CYC(TB), .LOSS_CYC(TB)) i_amps_link_monitor (
		.clk_in(clk_in), .nrst_in(nrst_in), .reset_n(link.reset_n),
		.power_down_n(link.power_down_n), .frame(link.frame),
		.byte_vld(link.byte_vld), .byte_dat(link.byte_dat));
	task automatic test_done;
		$display("comparisons %0d errors %0d", comparisons, num_errors);
		if (num_errors == 0 && comparisons > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input string n, input logic [31:0] e, s);
		comparisons++;
		if (s !== e) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a);
		@(posedge clk_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1 st = rdata_out;
	endtask
	task automatic poll(input logic [31:0] m, v);
		rd(4'h0);
		for (int i = 0; i < 3000 && (st & m) !== v; i++)
			rd(4'h0);
		chk("status", v, st & m);
	endtask
	task automatic snd(input logic [31:0] s, d);
		wr(4'h2, s);
		wr(4'h3, d);
		poll(32'h10, 32'h0);
	endtask
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done;
		end
	end
	initial begin
		repeat (6) @(posedge clk_in);
		nrst_in <= 1'b1;
		poll(32'hf, 32'h0);
		chk("shutdown", 1, sd);
		wr(4'h1, 32'h1);
		poll(32'hf, 32'h5);
		chk("trimmed", 1, trimmed);
		wr(4'h1, 32'h2);
		rd(4'h0);
		chk("early exit", 32'h45, st & 32'h4f);
		wr(4'h0, 32'h40);
		snd(32'h1a, 32'h21);
		chk("ramp", 32'h21, ramp);
		@(posedge clk_in);
		ce <= 1'b0;
		wr(4'h2, 32'h06);
		ce <= 1'b1;
		rd(4'h2);
		chk("frozen sub", 32'h1a, st);
		snd(32'h3b, 32'hfc00_0001);
		chk("thr1", 32'hfc00_0001, thr1);
		snd(32'h3e, 32'h0080_0000);
		chk("thr2", 32'h0080_0000, thr2);
		wr(4'h2, 32'h13c);
		wr(4'h3, 32'hfc80_0000);
		repeat (4) @(posedge clk_in);
		snd(32'h3c, 32'h03c0_0001);
		chk("avg w0", 32'h0080_0000, coef1[31:0]);
		chk("avg w1", 32'hffc0_0001, coef1[63:32]);
		chk("low band", 0, coef2[31:0]);
		repeat (60) @(posedge clk_in);
		wr(4'h1, 32'h2);
		poll(32'hf, 32'h8);
		chk("shutdown", 0, sd);
		snd(32'h06, 32'h1);
		chk("gain muted", 0, gain);
		snd(32'h06, 32'h0);
		chk("gain", 32'h0002_0000, gain);
		wr(4'h2, 32'h1a);
		wr(4'h3, 32'h33);
		rd(4'h0);
		chk("run refused", 32'h40, st & 32'h40);
		chk("ramp kept", 32'h21, ramp);
		wr(4'h1, 32'h4);
		poll(32'hf, 32'h5);
		chk("shutdown", 1, sd);
		wr(4'h1, 32'h10);
		poll(32'hf, 32'h0);
		chk("pdn", 0, link.power_down_n);
		chk("reset", 0, link.reset_n);
		wr(4'h1, 32'h1);
		poll(32'hf, 32'h5);
		wr(4'h1, 32'h8);
		poll(32'hf, 32'h0);
		chk("inputs low", 0, link.frame | link.power_down_n);
		test_done;
	end
endmodule
`default_nettype wire
